/* File: rtl/irq_pkg.sv */
// Constants, register map and carrier types of the vectored interrupt handler.
// Assumes one system clock and a synchronous active-low reset.
package irq_pkg;

    // ------------------------------------------------------------
    // Sources and timing
    // ------------------------------------------------------------
    localparam int          NUM_SOURCES     = 22;
    localparam int          NUM_PERIPH      = 12;
    localparam int          NUM_EXTERNAL    = 10;
    localparam int          IDX_W           = 5;
    localparam int          CALL_CYCLES     = 4;
    localparam logic [15:0] VEC_BASE        = 16'h0003;
    localparam int          VEC_STEP_SHIFT  = 3;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_ENABLE      = 8'h04;
    localparam logic [7:0]  OFS_PRIORITY    = 8'h08;
    localparam logic [7:0]  OFS_PEND_SET    = 8'h0c;
    localparam logic [7:0]  OFS_PEND_CLR    = 8'h10;
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h14;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h18;
    localparam logic [7:0]  OFS_SERVICE     = 8'h1c;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int          GIE_BIT         = 7;
    localparam int          EV_CALL_BIT     = 0;
    localparam int          EV_RETURN_FROM_IRQ_INSTRUCTION_BIT     = 1;
    localparam int          NUM_EVENTS      = 2;
    localparam logic [31:0] RST_ENABLE      = 32'h0000_0000;
    localparam logic [31:0] RST_PRIORITY    = 32'h0000_0000;
    localparam logic [31:0] RST_AUTO_CLEAR  = 32'h0000_0005;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef enum logic { LVL_LOW, LVL_HIGH } level_t;

    typedef struct packed {
        logic             valid;
        logic [15:0]      addr;
        logic [IDX_W-1:0] source;
        level_t           level;
    } call_t;

    typedef struct packed {
        logic instr_done;
        logic return_from_irq_instruction_done;
    } cpu_status_t;

endpackage

/* File: rtl/irq_handler.sv */
// Vectored interrupt handler: pending flags, enables, two-level priority,
// call sequencing toward the core, AXI4-Lite register slave.
// Assumes the core pulses instruction and return completion, one clock.
//
// Summary of operation
// - Twenty-two sources, two priority levels
// - Twelve peripheral sources, up to ten external
// - Valid source condition sets its pending flag
// - Flags set even when disabled; no request
// - Enabled flag requests call after current instruction
// - Routine ends with return; core resumes
// - Per-source enable bit gates requests
// - Global enable bit seven required
// - Global enable clear blocks every source
// - Designated sources auto-clear flag on vectoring
// - Flag still set: re-enter after one instruction
// - Software setting a flag acts as event
// - Sample every cycle; fastest response five cycles
// - High preempts low; high never preempted
// - Simultaneous: higher level, then fixed order
// - Priority bit per source, reset low
module irq_handler #(
    parameter int          N_SRC      = irq_pkg::NUM_SOURCES,
    parameter logic [31:0] AUTO_CLEAR = irq_pkg::RST_AUTO_CLEAR
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [N_SRC-1:0]     src_event,
    input  wire irq_pkg::cpu_status_t cpu_status,
    output irq_pkg::call_t            call,
    output logic                      irq,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);
    import irq_pkg::*;

    localparam int A_CALL = CALL_CYCLES;

    if (N_SRC < 1 || N_SRC > 32 || N_SRC > (1 << IDX_W)) begin : g_bad_n_src
        $error("N_SRC must lie between 1 and 32");
    end

    typedef enum logic { ST_RUN, ST_CALL } seq_t;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic             gie_q;
    logic [N_SRC-1:0] enable_q;
    logic [N_SRC-1:0] prio_q;
    logic [N_SRC-1:0] pending_q;
    logic [NUM_EVENTS-1:0] status_q;
    logic [NUM_EVENTS-1:0] mask_q;
    logic             act_hi_q;
    logic             act_lo_q;
    seq_t             st_q;
    logic [2:0]       cnt_q;
    logic [IDX_W-1:0] sel_idx_q;
    level_t           sel_lvl_q;
    logic             req_q;
    logic [IDX_W-1:0] req_idx_q;
    level_t           req_lvl_q;
    call_t            call_q;

    logic             aw_held_q;
    logic             w_held_q;
    logic [7:0]       waddr_q;
    logic [31:0]      wdata_q;
    logic [3:0]       wstrb_q;
    logic             bvalid_q;
    logic [1:0]       bresp_q;
    logic             awready_q;
    logic             wready_q;
    logic             arready_q;
    logic             rvalid_q;
    logic [31:0]      rdata_q;
    logic [1:0]       rresp_q;

    logic             do_write;
    logic [31:0]      wmask;
    logic [31:0]      wbits;
    logic [N_SRC-1:0] sw_set;
    logic [N_SRC-1:0] sw_clr;
    logic [N_SRC-1:0] auto_clr;
    logic             go;
    logic             call_end;
    logic             live_hi;

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign wmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign wbits    = wdata_q & wmask;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            waddr_q   <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                aw_held_q <= 1'b1;
                awready_q <= 1'b0;
                waddr_q   <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                w_held_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                if (waddr_q[7:5] == 3'h0 && waddr_q[1:0] == 2'b00)
                    bresp_q <= RESP_OKAY;
                else
                    bresp_q <= RESP_SLVERR;
            end
            // Ready returns only after the response, so one write at a time
            if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // Write-one strobes for the pending flags
    // software set
    assign sw_set = (do_write && waddr_q == OFS_PEND_SET) ? wbits[N_SRC-1:0] : '0;
    assign sw_clr = (do_write && waddr_q == OFS_PEND_CLR) ? wbits[N_SRC-1:0] : '0;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gie_q    <= 1'b0;
            enable_q <= RST_ENABLE[N_SRC-1:0];
            prio_q   <= RST_PRIORITY[N_SRC-1:0];
            mask_q   <= '0;
        end else if (do_write) begin
            if (waddr_q == OFS_CTRL && wstrb_q[0])
                gie_q <= wdata_q[GIE_BIT];
            if (waddr_q == OFS_ENABLE)
                enable_q <= (enable_q & ~wmask[N_SRC-1:0]) | wbits[N_SRC-1:0];
            if (waddr_q == OFS_PRIORITY)
                prio_q <= (prio_q & ~wmask[N_SRC-1:0]) | wbits[N_SRC-1:0];
            if (waddr_q == OFS_IRQ_MASK)
                mask_q <= (mask_q & ~wmask[NUM_EVENTS-1:0]) | wbits[NUM_EVENTS-1:0];
        end
    end

    // ------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------
    always_comb begin
        auto_clr = '0;
        if (call_end)
            auto_clr[sel_idx_q] = AUTO_CLEAR[sel_idx_q];
    end

    // set regardless of enable
    // Any set beats any clear in the same cycle, so no event is lost
    always_ff @(posedge aclk) begin
        if (!aresetn)
            pending_q <= '0;
        else
            pending_q <= (pending_q & ~(sw_clr | auto_clr)) | src_event | sw_set;
    end

    // ------------------------------------------------------------
    // Request detection and arbitration
    // ------------------------------------------------------------
    // sampled every cycle
    always_ff @(posedge aclk) begin
        logic [N_SRC-1:0] live;
        logic [N_SRC-1:0] hi_ok;
        logic [N_SRC-1:0] lo_ok;
        live = '0;
        hi_ok = '0;
        lo_ok = '0;
        if (!aresetn) begin
            req_q     <= 1'b0;
            req_idx_q <= '0;
            req_lvl_q <= LVL_LOW;
        end else begin
            live  = gie_q ? (pending_q & enable_q) : '0;
            // high only if none high active
            hi_ok = act_hi_q ? '0 : (live & prio_q);
            lo_ok = (act_hi_q || act_lo_q) ? '0 : (live & ~prio_q);
            req_q <= (hi_ok != '0) || (lo_ok != '0);
            req_idx_q <= '0;
            req_lvl_q <= LVL_LOW;
            if (hi_ok != '0) begin
                req_lvl_q <= LVL_HIGH;
                for (int i = N_SRC - 1; i >= 0; i--) begin
                    if (hi_ok[i])
                        req_idx_q <= i[IDX_W-1:0];
                end
            end else begin
                for (int i = N_SRC - 1; i >= 0; i--) begin
                    if (lo_ok[i])
                        req_idx_q <= i[IDX_W-1:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Call sequencing
    // ------------------------------------------------------------
    // enter at instruction boundary
    // a return is not a boundary; next instruction is
    // Recheck level against live service state: the request is a cycle old
    assign go = st_q == ST_RUN && req_q && cpu_status.instr_done && !cpu_status.return_from_irq_instruction_done &&
                (req_lvl_q == LVL_HIGH ? !act_hi_q : !(act_hi_q || act_lo_q));
    // The entry cycle counts as the first call cycle, so response stays five
    assign call_end = st_q == ST_CALL && cnt_q == 3'(CALL_CYCLES - 2);
    assign live_hi  = gie_q && !act_hi_q && ((pending_q & enable_q & prio_q) != '0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q      <= ST_RUN;
            cnt_q     <= 3'h0;
            sel_idx_q <= '0;
            sel_lvl_q <= LVL_LOW;
        end else begin
            case (st_q)
                ST_RUN: begin
                    if (go) begin
                        st_q      <= ST_CALL;
                        cnt_q     <= 3'h0;
                        sel_idx_q <= req_idx_q;
                        sel_lvl_q <= req_lvl_q;
                    end
                end
                ST_CALL: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (call_end)
                        st_q <= ST_RUN;
                end
                default: st_q <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            call_q <= '0;
        end else begin
            call_q.valid  <= call_end;
            call_q.addr   <= VEC_BASE + 16'({sel_idx_q, 3'b000});
            call_q.source <= sel_idx_q;
            call_q.level  <= sel_lvl_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_hi_q <= 1'b0;
            act_lo_q <= 1'b0;
        end else begin
            if (cpu_status.return_from_irq_instruction_done) begin
                if (act_hi_q)
                    act_hi_q <= 1'b0;
                else
                    act_lo_q <= 1'b0;
            end
            if (call_end) begin
                if (sel_lvl_q == LVL_HIGH)
                    act_hi_q <= 1'b1;
                else
                    act_lo_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Event status and interrupt output
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        logic [NUM_EVENTS-1:0] ev;
        ev = '0;
        if (!aresetn) begin
            status_q <= '0;
            irq      <= 1'b0;
        end else begin
            ev[EV_CALL_BIT] = call_end;
            ev[EV_RETURN_FROM_IRQ_INSTRUCTION_BIT] = cpu_status.return_from_irq_instruction_done;
            if (do_write && waddr_q == OFS_IRQ_STATUS)
                status_q <= (status_q & ~wbits[NUM_EVENTS-1:0]) | ev;
            else
                status_q <= status_q | ev;
            irq <= (status_q & mask_q) != '0;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= 32'h0000_0000;
            if (s_axi_araddr == OFS_CTRL)
                rdata_q[GIE_BIT] <= gie_q;
            else if (s_axi_araddr == OFS_ENABLE)
                rdata_q[N_SRC-1:0] <= enable_q;
            else if (s_axi_araddr == OFS_PRIORITY)
                rdata_q[N_SRC-1:0] <= prio_q;
            else if (s_axi_araddr == OFS_PEND_SET || s_axi_araddr == OFS_PEND_CLR)
                rdata_q[N_SRC-1:0] <= pending_q;
            else if (s_axi_araddr == OFS_IRQ_STATUS)
                rdata_q[NUM_EVENTS-1:0] <= status_q;
            else if (s_axi_araddr == OFS_IRQ_MASK)
                rdata_q[NUM_EVENTS-1:0] <= mask_q;
            else if (s_axi_araddr == OFS_SERVICE)
                rdata_q[12:0] <= {st_q == ST_CALL, sel_idx_q, 1'b0, req_q,
                                  req_lvl_q == LVL_HIGH, 2'b00, act_hi_q, act_lo_q};
            else
                rresp_q <= RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign call          = call_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        (src_event != '0) |=> ((pending_q & $past(src_event)) == $past(src_event)))
        else $error("event did not set its pending flag");
    a_disabled_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        ((pending_q & enable_q) == '0) |=> !req_q)
        else $error("request raised with no enabled pending flag");
    a_global_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !gie_q |=> !req_q)
        else $error("request raised with global enable clear");
    a_call_latency: assert property (@(posedge aclk) disable iff (!aresetn)
        go |=> !call_q.valid [*3] ##1 call_q.valid)
        else $error("call did not complete after four cycles");
    a_call_vector: assert property (@(posedge aclk) disable iff (!aresetn)
        go |-> ##A_CALL (call_q.addr == VEC_BASE + 16'({$past(req_idx_q, A_CALL), 3'b000})))
        else $error("call vector does not match chosen source");
    a_high_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        act_hi_q |=> !call_q.valid)
        else $error("call completed while high level in service");
    a_return_from_irq_instruction_boundary: assert property (@(posedge aclk) disable iff (!aresetn)
        (cpu_status.return_from_irq_instruction_done && st_q == ST_RUN) |=> st_q == ST_RUN)
        else $error("entry on the return itself");
    a_level_first: assert property (@(posedge aclk) disable iff (!aresetn)
        (req_q && req_lvl_q == LVL_LOW) |-> !$past(live_hi))
        else $error("low level chosen over live high level");
    a_auto_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (call_end && AUTO_CLEAR[sel_idx_q] && !src_event[sel_idx_q] && !sw_set[sel_idx_q])
            |=> !pending_q[$past(sel_idx_q)])
        else $error("designated flag not cleared on vectoring");
    a_sw_set: assert property (@(posedge aclk) disable iff (!aresetn)
        (sw_set != '0) |=> ((pending_q & $past(sw_set)) == $past(sw_set)))
        else $error("software set of a flag was lost");

    c_high_call: cover property (@(posedge aclk) disable iff (!aresetn)
        call_q.valid && call_q.level == LVL_HIGH);
    c_preempt: cover property (@(posedge aclk) disable iff (!aresetn)
        go && act_lo_q);
    c_reenter: cover property (@(posedge aclk) disable iff (!aresetn)
        cpu_status.return_from_irq_instruction_done && req_q ##[1:20] go);

endmodule

/* File: dv/cpu_model.sv */
// Behavioural core model: instruction boundaries and return completion.
// Assumes the handler's clock and reset; ret_req is a one-cycle pulse.
module cpu_model (
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic            ret_req,
    input  wire logic            slow,
    output irq_pkg::cpu_status_t cpu_status
);
    timeunit 1ns;
    timeprecision 1ps;
    import irq_pkg::*;

    logic ph_q;

    // ----------------------------------------------------------------
    // Boundaries
    // ----------------------------------------------------------------
    // return, then boundaries
    // Slow mode completes an instruction every other cycle, like long opcodes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_status <= '0;
            ph_q       <= 1'b0;
        end else begin
            ph_q                  <= ~ph_q;
            cpu_status.return_from_irq_instruction_done  <= ret_req;
            cpu_status.instr_done <= !ret_req && (!slow || ph_q);
        end
    end
endmodule

/* File: dv/tb.sv */
// Self-checking bench of the interrupt handler, AXI4-Lite master tasks.
// Assumes the core model in cpu_model and the register map of irq_pkg.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_pkg::*;

    logic                   aclk = 0, aresetn = 0, ret_req = 0, slow = 0;
    logic [NUM_SOURCES-1:0] src_event = '0;
    logic [7:0]             s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]            s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]             s_axi_wstrb = 4'hf;
    logic                   s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic                   s_axi_arvalid = 0, s_axi_rready = 0;
    logic                   s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic                   s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]             s_axi_bresp, s_axi_rresp;
    cpu_status_t            cpu_status;
    call_t                  call, lc;
    int                     n_errors = 0, compares = 0, ncall = 0;

    always #5 aclk = ~aclk;

    irq_handler irq_handler_i (.aclk(aclk), .aresetn(aresetn), .src_event(src_event),
        .cpu_status(cpu_status), .call(call), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    cpu_model cpu_model_i (.aclk(aclk), .aresetn(aresetn), .ret_req(ret_req),
        .slow(slow), .cpu_status(cpu_status));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    // Calls are recorded here so that none is missed while a bus task runs
    always @(posedge aclk) begin
        if (call.valid === 1'b1) begin
            ncall <= ncall + 1;
            lc    <= call;
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata  <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = '1, input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata & m, e);
        chk(s_axi_rresp, er);
    endtask

    task automatic return_from_irq_instruction();
        @(posedge aclk);
        ret_req <= 1'b1;
        @(posedge aclk);
        ret_req <= 1'b0;
    endtask

    task automatic svc_end(input int s);
        wr(OFS_PEND_CLR, 32'h1 << s);
        return_from_irq_instruction();
    endtask

    task automatic ecall(input int s, input level_t lv);
        int c0;
        int n;
        c0 = ncall;
        n = 0;
        while (ncall == c0 && n < 60) begin
            @(posedge aclk);
            n++;
        end
        chk(ncall, c0 + 1);
        chk(lc.source, s);
        chk(lc.addr, VEC_BASE + (s << VEC_STEP_SHIFT));
        chk(lc.level, lv);
    endtask

    task automatic nocall(input int n);
        int c0;
        c0 = ncall;
        repeat (n) @(posedge aclk);
        chk(ncall, c0);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(OFS_CTRL, 32'h0);
        rd(OFS_ENABLE, RST_ENABLE);
        rd(OFS_PRIORITY, RST_PRIORITY);
        rd(8'h20, 32'h0, '1, RESP_SLVERR);
        wr(8'h20, 32'h1, RESP_SLVERR);
    endtask

    task automatic t_gate();
        @(posedge aclk);
        src_event <= '1;
        @(posedge aclk);
        src_event <= '0;
        wr(OFS_ENABLE, 32'h003f_ffff);
        nocall(12);
        rd(OFS_PEND_SET, 32'h003f_ffff);
        wr(OFS_PEND_CLR, 32'h003f_fff7);
        wr(OFS_ENABLE, 32'h0000_0008);
        wr(OFS_CTRL, 32'h0000_0080);
        ecall(3, LVL_LOW);
        rd(OFS_SERVICE, 32'h1, 32'h3);
        rd(OFS_PEND_SET, 32'h8, 32'h8);
        svc_end(3);
        nocall(15);
        rd(OFS_SERVICE, 32'h0, 32'h3);
    endtask

    task automatic t_latency();
        int n;
        n = 0;
        wr(OFS_ENABLE, 32'h0000_0001);
        @(posedge aclk);
        src_event[0] <= 1'b1;
        @(posedge aclk);
        src_event[0] <= 1'b0;
        do begin
            @(posedge aclk);
            #1;
            n++;
        end while (call.valid !== 1'b1 && n < 20);
        chk(n, CALL_CYCLES + 1);
        chk(call.addr, VEC_BASE);
        rd(OFS_PEND_SET, 32'h0, 32'h1);
        return_from_irq_instruction();
    endtask

    task automatic t_reenter();
        @(posedge aclk);
        slow <= 1'b1;
        wr(OFS_ENABLE, 32'h0000_0020);
        wr(OFS_PEND_SET, 32'h0000_0020);
        ecall(5, LVL_LOW);
        return_from_irq_instruction();
        ecall(5, LVL_LOW);
        svc_end(5);
        nocall(15);
        slow <= 1'b0;
    endtask

    task automatic t_prio();
        wr(OFS_PRIORITY, 32'h0000_0640);
        wr(OFS_ENABLE, 32'h0000_06d0);
        wr(OFS_PEND_SET, 32'h0000_02d0);
        ecall(6, LVL_HIGH);
        nocall(15);
        svc_end(6);
        ecall(9, LVL_HIGH);
        svc_end(9);
        ecall(4, LVL_LOW);
        wr(OFS_PEND_SET, 32'h0000_0400);
        ecall(10, LVL_HIGH);
        svc_end(10);
        nocall(12);
        svc_end(4);
        ecall(7, LVL_LOW);
        svc_end(7);
    endtask

    task automatic t_irq();
        wr(OFS_IRQ_MASK, 32'h0);
        rd(OFS_IRQ_STATUS, 32'h3, 32'h3);
        chk(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b1);
        wr(OFS_IRQ_STATUS, 32'h3);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        rd(OFS_IRQ_STATUS, 32'h0, 32'h3);
    endtask

    // ----------------------------------------------------------------
    // Sequence and verdict
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_gate();
        t_latency();
        t_reenter();
        t_prio();
        t_irq();
        test_done();
    end

    // The whole sequence needs a few hundred cycles; this is far beyond
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
endmodule
